// ==== pkg/ebpm_params.svh ====
// Purpose: constants of the external bus pin multiplexer
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes: pin-side levels are the idle (inactive) levels of each strobe
//
// Notes on behaviour
// - Each shared pin follows the controller that currently owns the bus.
// - Eight static chip selects, active low, one per memory area.
// - Upper byte select active low; shares pin with second write and card I/O read.
// - Lower byte select active low; shares pin with address bit zero.
// - Two active-low card chip enables share static selects five and six.
// - Card read-not-write rides address pin 25, steering card data buffer.
// - Card I/O read and write strobes, active low, on byte-select pins.
// - NAND chip select active low, shared with static select three.
// - NAND output enable active low, shared with burst-flash ready input.
// - SDRAM chip select active low, shared with static select one.
// - SDRAM address bit ten has its own dedicated output.
// - Burst-flash chip select active low, shared with static select zero.
// - Burst-flash address valid, active low, marks address latching.
// - Burst-flash address advance active low, shared with NAND write enable.
// - Burst-flash ready input is active high.
// - Burst-flash write enable active low on a dedicated pin.
// - Burst-flash output enable active low on a dedicated pin.
// - Hold address and controls stable when idle; respect data float times.
// - SDRAM refresh blocks others only while SDRAM already owns the bus; flash page bursts never interrupted.
`ifndef EBPM_PARAMS_SVH
`define EBPM_PARAMS_SVH

`define EBPM_ADDR_W      26
`define EBPM_DATA_W      32
`define EBPM_HALF_W      16
`define EBPM_NCS         8
`define EBPM_SDR_ADDR_W  13
`define EBPM_BF_ADDR_W   25
`define EBPM_SDR_SHIFT   2
`define EBPM_BF_SHIFT    1
`define EBPM_CS_IDLE     8'hff
`define EBPM_CS_BF       0
`define EBPM_CS_SDR      1
`define EBPM_CS_NAND     3
`define EBPM_CS_CARD     4
`define EBPM_CS_CE1      5
`define EBPM_CS_CE2      6
`define EBPM_CARD_RNW    25
`define EBPM_FLOAT_CYC   2

`endif

// ==== pkg/ebpm_pkg.sv ====
// Purpose: types of the external bus pin multiplexer
// Assumes: nothing
// Notes: owner codes are one-hot
`default_nettype none
package ebpm_pkg;
    typedef enum logic [3:0] {
        OWN_IDLE   = 4'h1,
        OWN_STATIC = 4'h2,
        OWN_SDRAM  = 4'h4,
        OWN_FLASH  = 4'h8
    } ebpm_owner_type;
endpackage
`default_nettype wire

// ==== core/ebpm_float_timer.sv ====
// Purpose: counts data float cycles after a controller releases the data bus
// Assumes: start pulses come from the same clock domain
// Notes: busy stays high for FLOAT cycles after start
`include "ebpm_params.svh"
`default_nettype none
module ebpm_float_timer #(
    parameter int unsigned FLOAT = `EBPM_FLOAT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic start,
    output var  logic busy
);
    // Four-bit counter cannot hold more than fifteen float cycles
    if (FLOAT < 1 || FLOAT > 15) begin : gBadFloat
        $error("FLOAT out of range");
    end

    logic [3:0] cnt_ff;
    wire  [3:0] nxt_cnt = start ? 4'(FLOAT) : (cnt_ff != 4'h0 ? cnt_ff - 4'h1 : 4'h0);

    // Down counter; busy derived from count
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    assign busy = (cnt_ff != 4'h0);
endmodule
`default_nettype wire

// ==== core/ebpm_pin_mux.sv ====
// Purpose: shares external address, data and strobe pins among three controllers
// Assumes: controllers drive active-low strobes, each raises req while it needs the pins
// Notes: arbitration is simple priority with burst and refresh carve-outs
`include "ebpm_params.svh"
`default_nettype none
module ebpm_pin_mux
    import ebpm_pkg::*;
#(
    parameter int unsigned FLOAT = `EBPM_FLOAT_CYC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Static memory controller
    input  wire logic                        smReq,
    input  wire logic [`EBPM_ADDR_W-1:0]     smAddr,
    input  wire logic [`EBPM_NCS-1:0]        smChipSelectN,
    input  wire logic                        smReadN,
    input  wire logic [1:0]                  smWriteN,
    input  wire logic                        smByteSelHiN,
    input  wire logic                        smByteSelLoN,
    input  wire logic                        smWide,
    input  wire logic                        smNandEn,
    input  wire logic                        smNandWeN,
    input  wire logic                        smNandOeN,
    input  wire logic                        smCardEn,
    input  wire logic                        smCardIoReadN,
    input  wire logic                        smCardIoWriteN,
    input  wire logic                        smCardRnw,
    input  wire logic [`EBPM_HALF_W-1:0]     smWrData,
    input  wire logic                        smDataOe,
    output logic                             smGrant,
    // SDRAM controller
    input  wire logic                        sdReq,
    input  wire logic                        sdRefresh,
    input  wire logic [`EBPM_SDR_ADDR_W-1:0] sdAddr,
    input  wire logic                        sdChipSelectN,
    input  wire logic [3:0]                  sdByteMaskN,
    input  wire logic [`EBPM_DATA_W-1:0]     sdWrData,
    input  wire logic                        sdDataOe,
    output logic                             sdGrant,
    // Burst flash controller
    input  wire logic                        bfReq,
    input  wire logic                        bfBurst,
    input  wire logic [`EBPM_BF_ADDR_W-1:0]  bfAddr,
    input  wire logic                        bfSelectN,
    input  wire logic                        bfAddrValidN,
    input  wire logic                        bfAddrAdvanceN,
    input  wire logic                        bfOutputEnableN,
    input  wire logic                        bfWriteEnableN,
    input  wire logic [`EBPM_HALF_W-1:0]     bfWrData,
    input  wire logic                        bfDataOe,
    output logic                             bfGrant,
    output logic                             bfReadyOut,
    // Read data to controllers
    output logic [`EBPM_DATA_W-1:0]          rdData,
    // Pins
    output logic [`EBPM_ADDR_W-1:0]          addrPin,
    output logic [`EBPM_NCS-1:0]             chipSelPinN,
    output logic                             readPinN,
    output logic                             write0PinN,
    output logic                             upperBytePinN,
    output logic                             write3PinN,
    output logic                             sdramAddrBitTen,
    output logic                             burstFlashAddrValidN,
    output logic                             advancePinN,
    output logic                             burstFlashOutputEnableN,
    output logic                             burstFlashWriteEnableN,
    input  wire logic                        readyPinIn,
    output logic                             readyPinOut,
    output logic                             readyPinOe,
    input  wire logic [`EBPM_DATA_W-1:0]     dataPinIn,
    output logic [`EBPM_DATA_W-1:0]          dataPinOut,
    output logic [`EBPM_DATA_W-1:0]          dataPinOe
);
    import ebpm_pkg::*;

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic                    rdyMeta_ff, rdySync_ff;
    logic [`EBPM_DATA_W-1:0] datMeta_ff, datSync_ff;
    always_ff @(posedge clk) begin
        rdyMeta_ff <= readyPinIn;
        rdySync_ff <= rdyMeta_ff;
        datMeta_ff <= dataPinIn;
        datSync_ff <= datMeta_ff;
    end

    // ------------------------------------------------------------
    // Ownership
    // ------------------------------------------------------------
    ebpm_owner_type owner_ff;
    ebpm_owner_type nxt_owner;
    logic           floatBusy;
    logic           releaseData;
    logic           ownerDataOe;

    // burst hold and refresh
    // A flash page burst keeps the pins; refresh is granted without any pins, not even the SDRAM select, unless SDRAM already owns the bus.
    wire bfHold  = (owner_ff == OWN_FLASH) && bfBurst;
    wire curHeld = (owner_ff == OWN_STATIC && smReq) || (owner_ff == OWN_SDRAM && sdReq) ||
                   (owner_ff == OWN_FLASH && bfReq) || bfHold;
    wire sdDataReq = sdReq && !sdRefresh;

    always_comb begin
        nxt_owner = owner_ff;
        if (!curHeld && !floatBusy) begin
            if (bfReq)          nxt_owner = OWN_FLASH;
            else if (smReq)     nxt_owner = OWN_STATIC;
            else if (sdDataReq) nxt_owner = OWN_SDRAM;
            else                nxt_owner = OWN_IDLE;
        end
    end
    // Pins still driven count too: a controller often drops its enable together with req
    assign releaseData = (nxt_owner != owner_ff) && (ownerDataOe || (dataPinOe != '0));

    ebpm_float_timer #(.FLOAT(FLOAT)) uFloat (
        .clk   (clk),
        .srst  (srst),
        .start (releaseData),
        .busy  (floatBusy)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            owner_ff <= OWN_IDLE;
        end else begin
            owner_ff <= nxt_owner;
        end
    end

    wire isSm = (nxt_owner == OWN_STATIC);
    wire isSd = (nxt_owner == OWN_SDRAM);
    wire isBf = (nxt_owner == OWN_FLASH);
    assign ownerDataOe = (owner_ff == OWN_STATIC && smDataOe) ||
                         (owner_ff == OWN_SDRAM && sdDataOe) ||
                         (owner_ff == OWN_FLASH && bfDataOe);

    // ------------------------------------------------------------
    // Address mapping
    // ------------------------------------------------------------
    logic [`EBPM_ADDR_W-1:0] addr_ff;
    wire [`EBPM_ADDR_W-1:0] sdShifted = {11'h0, sdAddr[12:11], 1'b0, sdAddr[9:0], 2'b00};
    wire [`EBPM_ADDR_W-1:0] bfShifted = {bfAddr, 1'b0};
    wire smCardMode = isSm && smCardEn;
    wire [`EBPM_ADDR_W-1:0] smMapped = smCardMode ?
         {smCardRnw, smAddr[`EBPM_ADDR_W-2:1], (smWide ? smByteSelLoN : smAddr[0])} :
         {smAddr[`EBPM_ADDR_W-1:1], (smWide ? smByteSelLoN : smAddr[0])};
    // lower byte select on address zero
    wire [`EBPM_ADDR_W-1:0] nxt_addr = isSm ? smMapped : isSd ? sdShifted :
                                       isBf ? bfShifted : addr_ff;
    wire sdDqm0 = sdByteMaskN[0];
    wire sdDqm2 = sdByteMaskN[2];
    wire [`EBPM_ADDR_W-1:0] nxt_addrPin = isSd ?
         {nxt_addr[`EBPM_ADDR_W-1:2], sdDqm2, sdDqm0} : nxt_addr;

    // ------------------------------------------------------------
    // Strobe mapping
    // ------------------------------------------------------------
    // chip select sharing
    wire [`EBPM_NCS-1:0] nxt_cs = isSm ? smChipSelectN :
         isSd ? (`EBPM_CS_IDLE & ~(8'h01 << `EBPM_CS_SDR)) | {7'h0, sdChipSelectN} << 1 :
         isBf ? (`EBPM_CS_IDLE & ~8'h01) | {7'h0, bfSelectN} : `EBPM_CS_IDLE;
    // upper byte, second write and card I/O read
    wire nxt_upper = isSm ? (smCardMode ? smCardIoReadN :
                            (smWide ? smByteSelHiN : smWriteN[1])) :
                     isSd ? sdByteMaskN[1] : 1'b1;
    // card I/O write on the third byte pin
    wire nxt_w3 = isSm ? (smCardMode ? smCardIoWriteN : 1'b1) :
                  isSd ? sdByteMaskN[3] : 1'b1;
    wire nxt_rd = isSm ? smReadN : 1'b1;
    wire nxt_w0 = isSm ? smWriteN[0] : 1'b1;
    wire nxt_a10 = isSd ? sdAddr[10] : sdramAddrBitTen;
    wire nxt_avd = isBf ? bfAddrValidN : 1'b1;
    wire nxt_burst_flash_output_enable_n = isBf ? bfOutputEnableN : 1'b1;
    wire nxt_burst_flash_write_enable_n = isBf ? bfWriteEnableN : 1'b1;
    // advance shares the NAND write enable
    wire nandMode = isSm && smNandEn;
    wire nxt_adv = isBf ? bfAddrAdvanceN : nandMode ? smNandWeN : 1'b1;
    // NAND read enable drives the ready pin only in NAND mode
    wire nxt_rdyOe = nandMode;
    wire nxt_rdyOut = nandMode ? smNandOeN : 1'b1;

    wire [`EBPM_DATA_W-1:0] nxt_dout = isSd ? sdWrData :
         isBf ? {16'h0, bfWrData} : isSm ? {16'h0, smWrData} : dataPinOut;
    // no drive during float gap; upper half SDRAM only
    wire dOe = !floatBusy && (nxt_owner == owner_ff) &&
               ((isSm && smDataOe) || (isSd && sdDataOe) || (isBf && bfDataOe));
    wire [`EBPM_DATA_W-1:0] nxt_doe = dOe ? (isSd ? 32'hffffffff : 32'h0000ffff) : 32'h0;

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_ff                 <= '0;
            addrPin                 <= '0;
            chipSelPinN             <= `EBPM_CS_IDLE;
            readPinN                <= 1'b1;
            write0PinN              <= 1'b1;
            upperBytePinN           <= 1'b1;
            write3PinN              <= 1'b1;
            sdramAddrBitTen         <= 1'b0;
            burstFlashAddrValidN    <= 1'b1;
            advancePinN             <= 1'b1;
            burstFlashOutputEnableN <= 1'b1;
            burstFlashWriteEnableN  <= 1'b1;
            readyPinOut             <= 1'b1;
            readyPinOe              <= 1'b0;
            dataPinOut              <= '0;
            dataPinOe               <= '0;
        end else begin
            addr_ff                 <= nxt_addr;
            addrPin                 <= nxt_addrPin;
            chipSelPinN             <= nxt_cs;
            readPinN                <= nxt_rd;
            write0PinN              <= nxt_w0;
            upperBytePinN           <= nxt_upper;
            write3PinN              <= nxt_w3;
            sdramAddrBitTen         <= nxt_a10;
            burstFlashAddrValidN    <= nxt_avd;
            advancePinN             <= nxt_adv;
            burstFlashOutputEnableN <= nxt_burst_flash_output_enable_n;
            burstFlashWriteEnableN  <= nxt_burst_flash_write_enable_n;
            readyPinOut             <= nxt_rdyOut;
            readyPinOe              <= nxt_rdyOe;
            dataPinOut              <= nxt_dout;
            dataPinOe               <= nxt_doe;
        end
    end

    // Grants and returned data
    always_ff @(posedge clk) begin
        if (srst) begin
            smGrant    <= 1'b0;
            sdGrant    <= 1'b0;
            bfGrant    <= 1'b0;
            bfReadyOut <= 1'b0;
            rdData     <= '0;
        end else begin
            smGrant    <= isSm;
            // refresh granted regardless of other owners
            sdGrant    <= isSd || (sdReq && sdRefresh);
            bfGrant    <= isBf;
            bfReadyOut <= isBf && !nandMode && rdySync_ff;
            rdData     <= datSync_ff;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // float gap respected
    float_gap_a: assert property (@(posedge clk) disable iff (srst)
        releaseData |=> dataPinOe == 32'h0)
        else $error("data driven during float gap");
    burst_hold_a: assert property (@(posedge clk) disable iff (srst)
        (owner_ff == OWN_FLASH && bfBurst) |=> owner_ff == OWN_FLASH)
        else $error("flash burst interrupted");
    cs_idle_a: assert property (@(posedge clk) disable iff (srst)
        (owner_ff == OWN_IDLE) |-> chipSelPinN == `EBPM_CS_IDLE)
        else $error("chip select active while idle");
    sd_cs_a: assert property (@(posedge clk) disable iff (srst)
        isSd |=> chipSelPinN[1] == $past(sdChipSelectN))
        else $error("sdram select misrouted");
    // bit ten held when not SDRAM
    a10_hold_a: assert property (@(posedge clk) disable iff (srst)
        !isSd |=> $stable(sdramAddrBitTen))
        else $error("bit ten moved");
    upper_data_a: assert property (@(posedge clk) disable iff (srst)
        (owner_ff != OWN_SDRAM) |-> dataPinOe[31:16] == 16'h0)
        else $error("upper data driven by non-SDRAM");
    // ready pin only driven for NAND
    rdy_drive_a: assert property (@(posedge clk) disable iff (srst)
        readyPinOe |-> $past(nandMode))
        else $error("ready pin driven outside NAND");
    // flash write idle when not flash
    bf_we_a: assert property (@(posedge clk) disable iff (srst)
        (owner_ff != OWN_FLASH) |-> burstFlashWriteEnableN)
        else $error("flash write outside flash owner");
endmodule
`default_nettype wire

// ==== testbench/ebpm_ext_model.sv ====
// Purpose: memories on the pin side of the bus multiplexer
// Assumes: static device on select two, burst flash on select zero
// Notes: released data lines show pull-ups low and a toggling pattern high
`default_nettype none
module ebpm_ext_model #(
    parameter int RDY_DLY = 3
) (
    // Clock
    input  wire logic        clk,
    // Pins from the multiplexer
    input  wire logic [7:0]  chipSelPinN,
    input  wire logic        readPinN,
    input  wire logic        burstFlashOutputEnableN,
    input  wire logic        readyPinOut,
    input  wire logic        readyPinOe,
    input  wire logic [31:0] dataPinOut,
    input  wire logic [31:0] dataPinOe,
    // Pins back to the multiplexer
    output logic             readyPinIn,
    output logic [31:0]      dataPinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] hiNoise = 16'h0f0f;
    logic [31:0] devData;
    int          rdyCnt  = 0;

    // Upper half has no pull-up, so a floating line must not look steady
    always @(posedge clk) begin
        hiNoise <= ~hiNoise;
    end
    // Static device drives read data only while selected and read strobe low
    assign devData   = (!chipSelPinN[2] && !readPinN) ? {hiNoise, 16'h5a3c} : {hiNoise, 16'hffff};
    // Wire level from both parties
    assign dataPinIn = (dataPinOe & dataPinOut) | (~dataPinOe & devData);
    always @(posedge clk) begin
        rdyCnt <= (!chipSelPinN[0] && !burstFlashOutputEnableN) ? rdyCnt + 1 : 0;
    end
    assign readyPinIn = readyPinOe ? readyPinOut :
                        !chipSelPinN[0] ? (rdyCnt >= RDY_DLY) : hiNoise[0];
endmodule
`default_nettype wire

// ==== testbench/test_external_bus_pin_mux.sv ====
// Purpose: self-checking bench of the external bus pin multiplexer
// Assumes: inputs change 1 ns after the rising edge
// Notes: float gap kept at its default of two cycles
`default_nettype none
module test_external_bus_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;
    import ebpm_pkg::*;
    localparam int unsigned FLT = 2;
    // --------------------------------------------------
    // Signals
    // --------------------------------------------------
    logic        clk = 0, srst = 1;
    logic        smReq, smReadN, smByteSelHiN, smByteSelLoN, smWide, smNandEn, smNandWeN;
    logic        smNandOeN, smCardEn, smCardIoReadN, smCardIoWriteN, smCardRnw, smDataOe;
    logic        sdReq, sdRefresh, sdChipSelectN, sdDataOe, bfReq, bfBurst, bfSelectN;
    logic        bfAddrValidN, bfAddrAdvanceN, bfOutputEnableN, bfWriteEnableN, bfDataOe;
    logic        smGrant, sdGrant, bfGrant, bfReadyOut, readPinN, write0PinN, upperBytePinN;
    logic        write3PinN, sdramAddrBitTen, burstFlashAddrValidN, advancePinN;
    logic        burstFlashOutputEnableN, burstFlashWriteEnableN;
    logic        readyPinIn, readyPinOut, readyPinOe;
    logic [1:0]  smWriteN;
    logic [3:0]  sdByteMaskN;
    logic [7:0]  smChipSelectN, chipSelPinN;
    logic [12:0] sdAddr;
    logic [15:0] smWrData, bfWrData;
    logic [24:0] bfAddr;
    logic [25:0] smAddr, addrPin;
    logic [31:0] sdWrData, rdData, dataPinIn, dataPinOut, dataPinOe;
    int          miscompares = 0, n_tests = 0, cycles = 0;

    ebpm_pin_mux #(.FLOAT(FLT)) dut (.clk, .srst, .smReq, .smAddr, .smChipSelectN, .smReadN,
        .smWriteN, .smByteSelHiN, .smByteSelLoN, .smWide, .smNandEn, .smNandWeN, .smNandOeN,
        .smCardEn, .smCardIoReadN, .smCardIoWriteN, .smCardRnw, .smWrData, .smDataOe, .smGrant,
        .sdReq, .sdRefresh, .sdAddr, .sdChipSelectN, .sdByteMaskN, .sdWrData, .sdDataOe,
        .sdGrant, .bfReq, .bfBurst, .bfAddr, .bfSelectN, .bfAddrValidN, .bfAddrAdvanceN,
        .bfOutputEnableN, .bfWriteEnableN, .bfWrData, .bfDataOe, .bfGrant, .bfReadyOut,
        .rdData, .addrPin, .chipSelPinN, .readPinN, .write0PinN, .upperBytePinN, .write3PinN,
        .sdramAddrBitTen, .burstFlashAddrValidN, .advancePinN, .burstFlashOutputEnableN,
        .burstFlashWriteEnableN, .readyPinIn, .readyPinOut, .readyPinOe, .dataPinIn,
        .dataPinOut, .dataPinOe);

    ebpm_ext_model #(.RDY_DLY(3)) ext (.clk, .chipSelPinN, .readPinN, .burstFlashOutputEnableN,
        .readyPinOut, .readyPinOe, .dataPinOut, .dataPinOe, .readyPinIn, .dataPinIn);

    // --------------------------------------------------
    // Clock, timeout and helpers
    // --------------------------------------------------
    always #2 clk = ~clk;
    // Tests need under a hundred cycles; a hang is cut well beyond that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle_all();
        {smReq, smWide, smNandEn, smCardEn, smCardRnw, smDataOe, sdReq, sdRefresh} = '0;
        {sdDataOe, bfReq, bfBurst, bfDataOe} = '0;
        {smReadN, smByteSelHiN, smByteSelLoN, smNandWeN, smNandOeN, smCardIoReadN} = '1;
        {smCardIoWriteN, sdChipSelectN, bfSelectN, bfAddrValidN, bfAddrAdvanceN} = '1;
        {bfOutputEnableN, bfWriteEnableN, smWriteN, sdByteMaskN, smChipSelectN} = '1;
        {smAddr, smWrData, bfWrData, bfAddr, sdAddr, sdWrData} = '0;
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // --------------------------------------------------
    // Scenarios
    // --------------------------------------------------
    task automatic t_reset();
        chk({smGrant, sdGrant, bfGrant, readyPinOe}, 4'h0);
        chk(chipSelPinN, 8'hff);
        chk(addrPin, 26'h0);
        chk(dataPinOe, 32'h0);
        chk({readPinN, write0PinN, upperBytePinN, write3PinN, burstFlashAddrValidN, advancePinN,
             burstFlashOutputEnableN, burstFlashWriteEnableN}, 8'hff);
        $display("reset values done");
    endtask
    task automatic t_static();
        {smReq, smWide, smDataOe, smByteSelHiN} = 4'he;
        smAddr = 26'h2a5c3f6;
        smChipSelectN = 8'hfb;
        smWrData = 16'hc3a5;
        cyc(2);
        chk(smGrant, 1'b1);
        chk(chipSelPinN, 8'hfb);
        chk(addrPin[25:1], 25'h152e1fb);
        chk({addrPin[0], upperBytePinN}, 2'b10);
        chk(dataPinOe, 32'h0000ffff);
        chk(dataPinOut[15:0], 16'hc3a5);
        {smByteSelLoN, smByteSelHiN} = 2'b01;
        cyc(2);
        chk({addrPin[0], upperBytePinN}, 2'b01);
        idle_all();
        cyc(5);
        chk(addrPin[25:1], 25'h152e1fb);
        chk({chipSelPinN, upperBytePinN, smGrant}, 10'h3fe);
        $display("static access done");
    endtask
    task automatic t_sdram();
        {sdReq, sdDataOe, sdChipSelectN} = 3'b110;
        {sdAddr, sdByteMaskN, sdWrData} = {13'h1d6b, 4'h5, 32'h8badf00d};
        cyc(3);
        chk({sdGrant, chipSelPinN[1]}, 2'b10);
        chk(addrPin[11:2], sdAddr[9:0]);
        chk(sdramAddrBitTen, sdAddr[10]);
        chk(addrPin[14:13], sdAddr[12:11]);
        chk({write3PinN, addrPin[1], upperBytePinN, addrPin[0]}, 4'h5);
        chk(dataPinOe, 32'hffffffff);
        chk(dataPinOut, 32'h8badf00d);
        {sdReq, sdDataOe, sdChipSelectN, smReq, smDataOe} = 5'b00111;
        {smChipSelectN, smWriteN, smWrData} = {8'hfb, 2'h2, 16'h1e2d};
        cyc(1);
        chk({smGrant, dataPinOe}, 33'h100000000);
        cyc(1);
        chk({smGrant, dataPinOe}, 33'h100000000);
        cyc(5);
        chk({smGrant, dataPinOe}, 33'h10000ffff);
        chk({write0PinN, upperBytePinN}, 2'b01);
        {sdReq, sdRefresh} = 2'b11;
        cyc(3);
        chk({smGrant, sdGrant, chipSelPinN}, 10'h3fb);
        {sdReq, sdRefresh, smDataOe, smReadN, smWriteN} = 5'b00011;
        cyc(6);
        chk({readPinN, rdData[15:0]}, 17'h05a3c);
        idle_all();
        cyc(5);
        $display("sdram and float done");
    endtask
    task automatic t_flash();
        {bfReq, bfBurst, bfSelectN, bfAddrValidN, bfAddrAdvanceN, bfOutputEnableN} = 6'b110000;
        {bfDataOe, bfAddr, bfWrData} = {1'b1, 25'h1b3c5a7, 16'h6e21};
        cyc(2);
        {smReq, smChipSelectN} = {1'b1, 8'hfb};
        cyc(2);
        chk({bfGrant, smGrant}, 2'b10);
        chk(addrPin[25:1], bfAddr);
        chk({chipSelPinN[0], burstFlashAddrValidN, advancePinN}, 3'b000);
        chk({burstFlashOutputEnableN, burstFlashWriteEnableN, readyPinOe}, 3'b010);
        chk({dataPinOe, dataPinOut[15:0]}, 48'h0000ffff6e21);
        {bfAddrValidN, bfWriteEnableN, bfOutputEnableN} = 3'b101;
        cyc(2);
        chk({burstFlashAddrValidN, burstFlashWriteEnableN}, 2'b10);
        bfOutputEnableN = 0;
        cyc(8);
        chk(bfReadyOut, 1'b1);
        {bfReq, bfDataOe} = 2'b00;
        cyc(4);
        chk({bfGrant, smGrant}, 2'b10);
        bfBurst = 0;
        cyc(6);
        chk({bfGrant, smGrant}, 2'b01);
        idle_all();
        cyc(5);
        $display("burst flash done");
    endtask
    task automatic t_card_nand();
        {smReq, smCardEn, smCardRnw, smCardIoReadN} = 4'b1110;
        smChipSelectN = 8'h9f;
        cyc(3);
        chk({addrPin[25], chipSelPinN[6:5]}, 3'b100);
        chk({upperBytePinN, write3PinN}, 2'b01);
        {smCardRnw, smCardIoReadN, smCardIoWriteN} = 3'b010;
        cyc(2);
        chk({addrPin[25], upperBytePinN, write3PinN}, 3'b010);
        {smCardEn, smNandEn, smNandOeN, smNandWeN, smChipSelectN} = {4'b0101, 8'hf7};
        cyc(3);
        chk({chipSelPinN[3], readyPinOe, readyPinOut, advancePinN}, 4'b0101);
        {smNandOeN, smNandWeN} = 2'b10;
        cyc(2);
        chk({readyPinOe, readyPinOut, advancePinN}, 3'b110);
        idle_all();
        cyc(5);
        $display("card and nand done");
    endtask
    // --------------------------------------------------
    // Main sequence
    // --------------------------------------------------
    initial begin
        idle_all();
        cyc(20);
        srst = 0;
        t_reset();
        t_static();
        t_sdram();
        t_flash();
        t_card_nand();
        test_done();
    end
endmodule
`default_nettype wire
